/* File: include/ctm_pkg.sv */
// Purpose: Shared constants for the charge time edge control block
// Assumes: 16-bit registers on a plain strobe port
// Notes: Word addresses, one register per address
package ctm_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_CTL_LOW = 3'h0;
   localparam logic [2:0] ADDR_CTL_HIGH = 3'h1;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h2;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
   localparam logic [2:0] ADDR_UNIT_STAT = 3'h4;
   // ----------------------------------------------------------------
   // Control low fields
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_DELAY_MODE = 12;
   localparam int BIT_EDGE_GATE = 11;
   localparam int BIT_EDGE_ORDER = 10;
   localparam int BIT_SRC_GROUND = 9;
   localparam int BIT_TRIG_EN = 8;
   localparam int TRIM_LSB = 2;
   localparam int TRIM_W = 6;
   localparam int RANGE_LSB = 0;
   localparam int RANGE_W = 2;
   localparam logic [15:0] CTL_LOW_MASK = 16'hbfff;
   localparam logic [15:0] CTL_LOW_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // Control high fields
   // ----------------------------------------------------------------
   localparam int BIT_E1_SENS = 15;
   localparam int BIT_E1_POL = 14;
   localparam int E1_SRC_LSB = 10;
   localparam int BIT_E2_FLAG = 9;
   localparam int BIT_E1_FLAG = 8;
   localparam int BIT_E2_SENS = 7;
   localparam int BIT_E2_POL = 6;
   localparam int E2_SRC_LSB = 2;
   localparam int BIT_RANGE_HIGH = 0;
   localparam int SRC_W = 4;
   localparam logic [15:0] CTL_HIGH_MASK = 16'hfffd;
   localparam logic [15:0] CTL_HIGH_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // Interrupt status bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_EDGE1 = 0;
   localparam int IRQ_EDGE2 = 1;
   localparam int IRQ_PULSE = 2;
   localparam logic [15:0] RD_ZERO = 16'h0000;
endpackage

/* File: hw/ctm_edge_det.sv */
// Purpose: Edge or level detection of one selected edge source
// Assumes: Sources synchronous to I_CLK
// Notes: Output is a one-cycle event for edges, a level otherwise
module ctm_edge_det
   import ctm_pkg::*;
#(
   parameter int NSRC = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [NSRC-1:0] i_src,
   input wire logic [SRC_W-1:0] i_sel,
   input wire logic i_pol,
   input wire logic i_sens,
   output logic o_hit
);
   typedef struct packed {
      logic prev;
   } ctm_det_t;
   ctm_det_t s_q, s_d;
   logic cur;

   always_comb begin
      cur = i_src[i_sel] ~^ i_pol;
      // Raw source is kept, so a polarity change is not taken for an edge
      s_d.prev = i_src[i_sel];
      // Edge mode fires on the active transition, level mode while active
      if (i_sens) begin
         o_hit = cur & ~(s_q.prev ~^ i_pol);
      end else begin
         o_hit = cur;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* File: hw/ctm_unit.sv */
// Purpose: Digital control of the charge time measurement unit
// Assumes: Register port strobes and edge sources synchronous to I_CLK
// Notes: Delay pulse is the comparator output gated combinationally
//
// Local design decisions: the strobed register port and the register offsets.
import ctm_pkg::*;

module ctm_unit
   import ctm_pkg::*;
#(
   parameter int NSRC = 16
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic [2:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_IDLE,
   input wire logic [NSRC-1:0] I_EDGE1_SRC,
   input wire logic [NSRC-1:0] I_EDGE2_SRC,
   input wire logic I_CMP_TRIP,
   output logic O_SRC_ON,
   output logic O_SRC_GROUND,
   output logic O_ROUTE_CMP,
   output logic O_ROUTE_ADC,
   output logic O_ROUTE_DIODE,
   output logic signed [5:0] O_TRIM,
   output logic [1:0] O_RANGE,
   output logic O_RANGE_HIGH,
   output logic O_TRIGGER,
   output logic O_PULSE,
   output logic O_IRQ
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctl_lo;
      logic [15:0] ctl_hi;
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] mask;
      logic pulse_prev;
      logic [15:0] rdata;
   } ctm_state_t;
   ctm_state_t s_q, s_d;

   logic hit1_raw, hit2_raw;
   logic running, gate_ok, acc1, acc2, f1, f2, trip;
   logic wr_lo, wr_hi;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Write strobe aimed at one register address
   function automatic logic is_write(input logic wr, input logic [2:0] addr,
      input logic [2:0] target);
      return wr && addr == target;
   endfunction

   // Current flows only between the two edges
   function automatic logic flags_differ(input logic [15:0] hi);
      return hi[BIT_E1_FLAG] ^ hi[BIT_E2_FLAG];
   endfunction

   ctm_edge_det #(.NSRC(NSRC)) u_det1 (
      .clk(I_CLK),
      .resetn(I_RESETN),
      .i_src(I_EDGE1_SRC),
      .i_sel(s_q.ctl_hi[E1_SRC_LSB +: SRC_W]),
      .i_pol(s_q.ctl_hi[BIT_E1_POL]),
      .i_sens(s_q.ctl_hi[BIT_E1_SENS]),
      .o_hit(hit1_raw)
   );

   ctm_edge_det #(.NSRC(NSRC)) u_det2 (
      .clk(I_CLK),
      .resetn(I_RESETN),
      .i_src(I_EDGE2_SRC),
      .i_sel(s_q.ctl_hi[E2_SRC_LSB +: SRC_W]),
      .i_pol(s_q.ctl_hi[BIT_E2_POL]),
      .i_sens(s_q.ctl_hi[BIT_E2_SENS]),
      .o_hit(hit2_raw)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      wr_lo = is_write(I_WR, I_ADDR, ADDR_CTL_LOW);
      wr_hi = is_write(I_WR, I_ADDR, ADDR_CTL_HIGH);
      running = s_q.ctl_lo[BIT_ENABLE]
         && !(s_q.ctl_lo[BIT_IDLE_STOP] && I_IDLE);
      gate_ok = running && s_q.ctl_lo[BIT_EDGE_GATE];
      acc1 = gate_ok && hit1_raw;
      acc2 = gate_ok && hit2_raw
         && (!s_q.ctl_lo[BIT_EDGE_ORDER] || s_q.ctl_hi[BIT_E1_FLAG]);
      trip = running && s_q.ctl_lo[BIT_DELAY_MODE] && I_CMP_TRIP;
      s_d.pulse_prev = trip;
      if (wr_lo) begin
         s_d.ctl_lo = I_WDATA & CTL_LOW_MASK;
      end
      // Hardware edge set wins over a software clear in the same cycle
      f1 = s_q.ctl_hi[BIT_E1_FLAG];
      f2 = s_q.ctl_hi[BIT_E2_FLAG];
      if (wr_hi) begin
         s_d.ctl_hi = I_WDATA & CTL_HIGH_MASK;
         f1 = I_WDATA[BIT_E1_FLAG];
         f2 = I_WDATA[BIT_E2_FLAG];
      end
      s_d.ctl_hi[BIT_E1_FLAG] = f1 | acc1;
      s_d.ctl_hi[BIT_E2_FLAG] = f2 | acc2;
      if (is_write(I_WR, I_ADDR, ADDR_IRQ_STAT)) begin
         s_d.stat = s_q.stat & ~I_WDATA[IRQ_W-1:0];
      end
      if (is_write(I_WR, I_ADDR, ADDR_IRQ_MASK)) begin
         s_d.mask = I_WDATA[IRQ_W-1:0];
      end
      s_d.stat[IRQ_EDGE1] = s_d.stat[IRQ_EDGE1] | acc1;
      s_d.stat[IRQ_EDGE2] = s_d.stat[IRQ_EDGE2] | acc2;
      s_d.stat[IRQ_PULSE] = s_d.stat[IRQ_PULSE] | (trip & ~s_q.pulse_prev);
      s_d.rdata = RD_ZERO;
      if (I_RD) begin
         unique case (I_ADDR)
            ADDR_CTL_LOW: s_d.rdata = s_q.ctl_lo;
            ADDR_CTL_HIGH: s_d.rdata = s_q.ctl_hi;
            ADDR_IRQ_STAT: s_d.rdata[IRQ_W-1:0] = s_q.stat;
            ADDR_IRQ_MASK: s_d.rdata[IRQ_W-1:0] = s_q.mask;
            ADDR_UNIT_STAT: s_d.rdata[0] = O_SRC_ON;
            default: s_d.rdata = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s_q.ctl_lo <= CTL_LOW_RESET;
         s_q.ctl_hi <= CTL_HIGH_RESET;
         s_q.stat <= '0;
         s_q.mask <= '0;
         s_q.pulse_prev <= 1'b0;
         s_q.rdata <= RD_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Current flows between the two edges; charging in delay mode
   assign O_SRC_ON = running && !s_q.ctl_lo[BIT_SRC_GROUND]
      && flags_differ(s_q.ctl_hi);
   assign O_SRC_GROUND = s_q.ctl_lo[BIT_SRC_GROUND];
   assign O_ROUTE_CMP = running && s_q.ctl_lo[BIT_DELAY_MODE];
   assign O_ROUTE_ADC = running && !s_q.ctl_lo[BIT_DELAY_MODE];
   assign O_ROUTE_DIODE = running
      && !flags_differ(s_q.ctl_hi);
   assign O_TRIM = s_q.ctl_lo[TRIM_LSB +: TRIM_W];
   assign O_RANGE = s_q.ctl_lo[RANGE_LSB +: RANGE_W];
   assign O_RANGE_HIGH = s_q.ctl_hi[BIT_RANGE_HIGH];
   assign O_TRIGGER = s_q.ctl_lo[BIT_TRIG_EN] && trip;
   assign O_PULSE = trip;
   assign O_RDATA = s_q.rdata;
   assign O_IRQ = |(s_q.stat & s_q.mask);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESETN);

   // Control and routing
   off_quiet_a: assert property (
      !s_q.ctl_lo[BIT_ENABLE] |-> !O_SRC_ON && !O_PULSE && !O_ROUTE_CMP)
      else $error("unit active while off");
   idle_stop_a: assert property (
      s_q.ctl_lo[BIT_IDLE_STOP] && I_IDLE |-> !O_SRC_ON && !O_PULSE)
      else $error("active in idle");
   idle_run_a: assert property (
      s_q.ctl_lo[BIT_ENABLE] && !s_q.ctl_lo[BIT_IDLE_STOP]
      |-> O_ROUTE_CMP || O_ROUTE_ADC)
      else $error("unit stopped without idle stop");
   route_sel_a: assert property (
      running |-> O_ROUTE_CMP != O_ROUTE_ADC)
      else $error("routing not exclusive");
   ground_a: assert property (
      s_q.ctl_lo[BIT_SRC_GROUND] |-> !O_SRC_ON)
      else $error("source on while grounded");
   trig_a: assert property (
      !s_q.ctl_lo[BIT_TRIG_EN] |-> !O_TRIGGER)
      else $error("trigger while disabled");
   trig_on_a: assert property (
      s_q.ctl_lo[BIT_TRIG_EN] && O_PULSE |-> O_TRIGGER)
      else $error("trigger missing with pulse");
   pulse_route_a: assert property (
      O_PULSE |-> O_ROUTE_CMP)
      else $error("pulse outside delay mode");
   pulse_stat_a: assert property (
      O_PULSE && !s_q.pulse_prev |=> s_q.stat[IRQ_PULSE])
      else $error("pulse rise not recorded");
   diode_eq_a: assert property (
      running && !flags_differ(s_q.ctl_hi) |-> O_ROUTE_DIODE && !O_SRC_ON)
      else $error("diode route wrong");

   // Edge flags
   gate_block_a: assert property (
      !s_q.ctl_lo[BIT_EDGE_GATE] && !wr_hi
      |=> $stable(s_q.ctl_hi[BIT_E1_FLAG]))
      else $error("edge passed gate");
   gate_hold_a: assert property (
      !s_q.ctl_lo[BIT_EDGE_GATE] && !wr_hi
      |=> $stable(s_q.ctl_hi[BIT_E2_FLAG]))
      else $error("edge two passed gate");
   order_a: assert property (
      s_q.ctl_lo[BIT_EDGE_ORDER] && !wr_hi
      && !s_q.ctl_hi[BIT_E1_FLAG] && !acc1
      |=> !$rose(s_q.ctl_hi[BIT_E2_FLAG]))
      else $error("edge 2 before edge 1");
   src_start_a: assert property (
      acc1 && !acc2 && !wr_hi && !wr_lo && !s_q.ctl_hi[BIT_E2_FLAG]
      && !s_q.ctl_lo[BIT_SRC_GROUND] |=> O_SRC_ON || !running)
      else $error("edge did not start charge");
   edge_set_a: assert property (
      acc1 |=> s_q.ctl_hi[BIT_E1_FLAG] && s_q.stat[IRQ_EDGE1])
      else $error("edge flag not set");
   edge2_set_a: assert property (
      acc2 |=> s_q.ctl_hi[BIT_E2_FLAG] && s_q.stat[IRQ_EDGE2])
      else $error("edge two flag not set");
   flag_load_a: assert property (
      wr_hi && !acc1
      |=> s_q.ctl_hi[BIT_E1_FLAG] == $past(I_WDATA[BIT_E1_FLAG]))
      else $error("edge flag not loaded");
   flag2_load_a: assert property (
      wr_hi && !acc2
      |=> s_q.ctl_hi[BIT_E2_FLAG] == $past(I_WDATA[BIT_E2_FLAG]))
      else $error("edge two flag not loaded");
   one_flag_a: assert property (
      s_q.ctl_hi[BIT_E1_FLAG] && s_q.ctl_hi[BIT_E2_FLAG]
      |-> !O_SRC_ON && O_ROUTE_DIODE == running)
      else $error("source on with both flags");

   // Register port
   bit14_a: assert property (
      I_RD && I_ADDR == ADDR_CTL_LOW |=> !O_RDATA[14])
      else $error("bit 14 reads one");
   lo_write_a: assert property (
      wr_lo |=> s_q.ctl_lo == ($past(I_WDATA) & CTL_LOW_MASK))
      else $error("control low write lost");
   hi_bit1_a: assert property (
      I_RD && I_ADDR == ADDR_CTL_HIGH |=> !O_RDATA[1])
      else $error("unused high bit reads one");
   rdata_idle_a: assert property (
      !I_RD |=> O_RDATA == RD_ZERO)
      else $error("read data outlived its cycle");
   bad_addr_a: assert property (
      I_RD && I_ADDR > ADDR_UNIT_STAT |=> O_RDATA == RD_ZERO)
      else $error("unmapped address read nonzero");
   unit_stat_a: assert property (
      I_RD && I_ADDR == ADDR_UNIT_STAT |=> O_RDATA[0] == $past(O_SRC_ON))
      else $error("unit status wrong");
   mask_wr_a: assert property (
      is_write(I_WR, I_ADDR, ADDR_IRQ_MASK)
      |=> s_q.mask == $past(I_WDATA[IRQ_W-1:0]))
      else $error("mask write lost");
   irq_clear_a: assert property (
      is_write(I_WR, I_ADDR, ADDR_IRQ_STAT) && I_WDATA[IRQ_EDGE1] && !acc1
      |=> !s_q.stat[IRQ_EDGE1])
      else $error("status bit not cleared");

   pulse_c: cover property ($rose(O_PULSE));
   charge_c: cover property ($rose(O_SRC_ON) ##[1:20] $fell(O_SRC_ON));
   irq_c: cover property ($rose(O_IRQ));
   order_c: cover property (gate_ok && s_q.ctl_lo[BIT_EDGE_ORDER]
      && hit2_raw && !acc2);
   diode_c: cover property (O_ROUTE_DIODE && O_ROUTE_ADC && O_RANGE[1]);
endmodule

/* File: verif/ctm_far_side.sv */
// Purpose: Edge sources and delay comparator beside the unit
// Assumes: Charge grows one step per cycle while the source drives
// Notes: Comparator trips once the charge reaches TRIP_CYC
module ctm_far_side #(
   parameter int TRIP_CYC = 20
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic i_src_on,
   input wire logic i_ground,
   input wire logic i_fire1,
   input wire logic i_fire2,
   output logic [15:0] o_edge1,
   output logic [15:0] o_edge2,
   output logic o_trip
);
   timeunit 1ns;
   timeprecision 1ps;
   int charge;
   // ----------------------------------------------------------------
   // Edge one on source 0, edge two on source 1
   // ----------------------------------------------------------------
   assign o_edge1 = {15'h0000, i_fire1};
   assign o_edge2 = {14'h0000, i_fire2, 1'b0};
   assign o_trip = (charge >= TRIP_CYC);
   // Grounding drains the capacitor
   always @(posedge clk or negedge resetn) begin
      if (!resetn || i_ground)
         charge <= 0;
      else if (i_src_on && charge < TRIP_CYC)
         charge <= charge + 1;
   end
endmodule

/* File: verif/charge_time_edge_control_bench.sv */
// Purpose: Self-checking bench of the charge time edge control block
// Assumes: Far side model supplies edges and the delay comparator
// Notes: Control cases run from a table, edges and pulses by hand
module charge_time_edge_control_bench;
   import ctm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, idle = 0, f1 = 0, f2 = 0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000, rdata, e1, e2;
   logic trip, src_on, gnd, rcmp, radc, rdio, trig, pulse, irq, rhi;
   logic signed [5:0] trim;
   logic [1:0] rng;
   int n_fail = 0, tests_run = 0;
   // Row: idle, control word, {cmp, adc, ground, trim, range}
   logic [27:0] rows [8] = '{
      {1'b0, 16'h9000, 11'h400}, {1'b0, 16'h8000, 11'h200},
      {1'b0, 16'h1000, 11'h000}, {1'b0, 16'h8200, 11'h300},
      {1'b0, 16'h807f, 11'h27f}, {1'b0, 16'h8087, 11'h287},
      {1'b1, 16'ha000, 11'h000}, {1'b1, 16'h8000, 11'h200}};
   ctm_unit i_ctm_unit (.I_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_IDLE(idle), .I_EDGE1_SRC(e1), .I_EDGE2_SRC(e2),
      .I_CMP_TRIP(trip), .O_SRC_ON(src_on), .O_SRC_GROUND(gnd),
      .O_ROUTE_CMP(rcmp), .O_ROUTE_ADC(radc), .O_ROUTE_DIODE(rdio),
      .O_TRIM(trim), .O_RANGE(rng), .O_RANGE_HIGH(rhi),
      .O_TRIGGER(trig), .O_PULSE(pulse), .O_IRQ(irq));
   ctm_far_side i_ctm_far_side (.clk(clk), .resetn(rstn),
      .i_src_on(src_on), .i_ground(gnd), .i_fire1(f1), .i_fire2(f2),
      .o_edge1(e1), .o_edge2(e2), .o_trip(trip));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // One pulse on the chosen edge source, then time to register it
   task automatic fire(input logic one);
      @(posedge clk);
      f1 <= one;
      f2 <= !one;
      @(posedge clk);
      f1 <= 1'b0;
      f2 <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rchk(ADDR_CTL_LOW, CTL_LOW_RESET);
      chk({5'h00, rcmp, radc, gnd, trim, rng}, 16'h0000);
      wreg(ADDR_CTL_LOW, 16'hffff);
      rchk(ADDR_CTL_LOW, 16'hbfff);
      wreg(3'h5, 16'hffff);
      rchk(3'h5, RD_ZERO);
      foreach (rows[i]) begin
         idle <= rows[i][27];
         wreg(ADDR_CTL_LOW, rows[i][26:11]);
         chk({5'h00, rcmp, radc, gnd, trim, rng}, {5'h00, rows[i][10:0]});
         rchk(ADDR_CTL_LOW, rows[i][26:11]);
      end
      idle <= 1'b0;
      wreg(ADDR_CTL_HIGH, 16'h0003);
      rchk(ADDR_CTL_HIGH, 16'h0001);
      chk({15'h0000, rhi}, 16'h0001);
      wreg(ADDR_CTL_LOW, 16'h8002);
      chk({12'h000, radc, rdio, rng}, 16'h000e);
      wreg(ADDR_CTL_HIGH, 16'hc0c4);
      wreg(ADDR_CTL_LOW, 16'h8000);
      fire(1'b1);
      rchk(ADDR_CTL_HIGH, 16'hc0c4);
      wreg(ADDR_CTL_LOW, 16'h8800);
      chk({15'h0000, rdio}, 16'h0001);
      fire(1'b1);
      rchk(ADDR_CTL_HIGH, 16'hc1c4);
      chk({14'h0000, src_on, rdio}, 16'h0002);
      fire(1'b0);
      rchk(ADDR_CTL_HIGH, 16'hc3c4);
      chk({14'h0000, src_on, rdio}, 16'h0001);
      rchk(ADDR_IRQ_STAT, 16'h0003);
      chk({15'h0000, irq}, 16'h0000);
      wreg(ADDR_IRQ_MASK, 16'h0002);
      chk({15'h0000, irq}, 16'h0001);
      rchk(ADDR_IRQ_MASK, 16'h0002);
      wreg(ADDR_IRQ_STAT, 16'h0002);
      chk({15'h0000, irq}, 16'h0000);
      rchk(ADDR_IRQ_STAT, 16'h0001);
      wreg(ADDR_CTL_HIGH, 16'hc1c4);
      chk({15'h0000, src_on}, 16'h0001);
      rchk(ADDR_UNIT_STAT, 16'h0001);
      wreg(ADDR_CTL_HIGH, 16'hc0c4);
      wreg(ADDR_CTL_LOW, 16'h8c00);
      fire(1'b0);
      rchk(ADDR_CTL_HIGH, 16'hc0c4);
      fire(1'b1);
      fire(1'b0);
      rchk(ADDR_CTL_HIGH, 16'hc3c4);
      wreg(ADDR_CTL_HIGH, 16'hc0c4);
      wreg(ADDR_CTL_LOW, 16'h8200);
      wreg(ADDR_CTL_LOW, 16'h9900);
      chk({15'h0000, pulse}, 16'h0000);
      fire(1'b1);
      chk({14'h0000, src_on, pulse}, 16'h0002);
      for (int k = 0; k < 200 && pulse !== 1'b1; k++)
         @(posedge clk);
      #1;
      chk({14'h0000, pulse, trig}, 16'h0003);
      rchk(ADDR_IRQ_STAT, 16'h0007);
      wreg(ADDR_CTL_LOW, 16'h9800);
      chk({14'h0000, pulse, trig}, 16'h0002);
      // Falling edge on source 0; the polarity switch itself is no edge
      wreg(ADDR_CTL_HIGH, 16'h80c4);
      rchk(ADDR_CTL_HIGH, 16'h80c4);
      fire(1'b1);
      rchk(ADDR_CTL_HIGH, 16'h81c4);
      give_verdict();
   end
endmodule
